// File: logic/mtfc_pkg.sv
// Purpose: shared constants of the transmit frame control block
// Assumes: byte-wide frame stream, 32-bit register bus
// Notes: offsets are byte addresses on the register bus
package mtfc_pkg;

   ////////////////////////////////////////////////////////////////////////
   // register map
   localparam int ADDR_W = 8;
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_MAXFL = 8'h04;
   localparam logic [7:0] REG_STATUS = 8'h08;

   // global config byte: pad code [7:5], crc enable [4], huge enable [2]
   localparam int CFG_PAD_LSB = 5;
   localparam int CFG_CRC_BIT = 4;
   localparam int CFG_HUGE_BIT = 2;
   localparam logic [7:0] CFG_MASK = 8'hF4;
   localparam logic [7:0] CFG_RESET = 8'h00;
   localparam logic [15:0] MAXFL_RESET = 16'h05EE;
   localparam logic [2:0] PAD_VLAN = 3'h5;

   // status word layout
   localparam int ST_BUSY_BIT = 0;
   localparam int ST_ABORT_BIT = 1;
   localparam int ST_CRCERR_BIT = 2;
   localparam int ST_CNT_LSB = 16;

   ////////////////////////////////////////////////////////////////////////
   // per packet control byte
   localparam int CB_OVERRIDE = 0;
   localparam int CB_CRC = 1;
   localparam int CB_PAD = 2;
   localparam int CB_HUGE = 3;

   ////////////////////////////////////////////////////////////////////////
   // frame constants
   localparam logic [7:0] PREAMBLE_BYTE = 8'h55;
   localparam logic [7:0] SFD_BYTE = 8'hD5;
   localparam logic [2:0] PRE_LAST = 3'h7;
   localparam logic [1:0] FCS_LAST = 2'h3;
   localparam logic [15:0] PAD_SHORT = 16'h003C;
   localparam logic [15:0] PAD_LONG = 16'h0040;
   localparam logic [15:0] TYPE_HI_IDX = 16'h000C;
   localparam logic [15:0] TYPE_LO_IDX = 16'h000D;
   localparam logic [7:0] VLAN_HI = 8'h81;
   localparam logic [7:0] VLAN_LO = 8'h00;
   localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;
   localparam logic [31:0] CRC_POLY = 32'hEDB88320;
   localparam logic [31:0] CRC_RESIDUE = 32'hDEBB20E3;

   typedef enum logic [6:0] {
      ST_IDLE = 7'h01,
      ST_PRE = 7'h02,
      ST_DATA = 7'h04,
      ST_PAD = 7'h08,
      ST_FCS = 7'h10,
      ST_DRAIN = 7'h20,
      ST_DONE = 7'h40
   } mtfc_state_type;

endpackage

// File: logic/mtfc_byte_if.sv
// Purpose: byte stream with valid/ready between the block's modules
// Assumes: single clock
// Notes: err marks a frame cut short, it rides on the last byte
`timescale 1ns/1ps
interface mtfc_byte_if;
   logic [7:0] data;
   logic valid;
   logic ready;
   logic last;
   logic err;
   modport src (output data, output valid, output last, output err,
                input ready);
   modport snk (input data, input valid, input last, input err,
                output ready);
endinterface

// File: logic/mtfc_crc_step.sv
// Purpose: one byte step of the reflected frame check sequence
// Assumes: caller holds the running value in a register
// Notes: purely combinational
`timescale 1ns/1ps
module mtfc_crc_step
   import mtfc_pkg::*;
(
   input wire logic [31:0] crc_in,
   input wire logic [7:0] byte_in,
   output logic [31:0] crc_out
);
   always_comb begin
      logic [31:0] c;
      c = crc_in ^ {24'h000000, byte_in};
      for (int i = 0; i < 8; i++) begin
         c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
      end
      crc_out = c;
   end
endmodule

// File: logic/mtfc_skid_buf.sv
// Purpose: small buffer so a stall on the medium side loses no byte
// Assumes: up and dn share the clock
// Notes: DEPTH must be a power of two
`timescale 1ns/1ps
module mtfc_skid_buf #(
   parameter int DEPTH = 2
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic ce,
   mtfc_byte_if.snk up,
   mtfc_byte_if.src dn
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
   logic [9:0] mem_r [DEPTH];
   logic [9:0] mem_nxt [DEPTH];
   logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
   logic [AW:0] cnt_r, cnt_nxt;
   logic push, pop;

   assign up.ready = (cnt_r != FULL);
   assign dn.valid = (cnt_r != '0);
   assign {dn.err, dn.last, dn.data} = mem_r[rp_r];
   assign push = up.valid & up.ready;
   assign pop = dn.valid & dn.ready;

   always_comb begin
      mem_nxt = mem_r;
      wp_nxt = wp_r;
      rp_nxt = rp_r;
      cnt_nxt = cnt_r;
      if (push) begin
         mem_nxt[wp_r] = {up.err, up.last, up.data};
         wp_nxt = wp_r + AW'(1);
      end
      if (pop) begin
         rp_nxt = rp_r + AW'(1);
      end
      if (push && !pop) begin
         cnt_nxt = cnt_r + (AW+1)'(1);
      end else if (pop && !push) begin
         cnt_nxt = cnt_r - (AW+1)'(1);
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         for (int i = 0; i < DEPTH; i++) begin
            mem_r[i] <= 10'h000;
         end
         wp_r <= '0;
         rp_r <= '0;
         cnt_r <= '0;
      end else if (ce) begin
         mem_r <= mem_nxt;
         wp_r <= wp_nxt;
         rp_r <= rp_nxt;
         cnt_r <= cnt_nxt;
      end
   end
endmodule

// File: logic/mtfc_top.sv
// Purpose: transmit frame assembly with per packet control byte
// Assumes: packet bytes come from same-clock logic, control byte first
// Notes: registers on AHB-Lite, zero wait states unless ce is low, always OKAY
//
// Design decisions made here: the address map and the AHB-Lite register port.
`timescale 1ns/1ps
module mtfc_top
   import mtfc_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic ce,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic [7:0] pkt_data,
   input wire logic pkt_valid,
   input wire logic pkt_last,
   output logic pkt_ready,
   output logic [7:0] tx_data,
   output logic tx_valid,
   output logic tx_last,
   output logic tx_abort,
   input wire logic tx_ready
);

   ////////////////////////////////////////////////////////////////////////
   // register bus slave
   logic [7:0] cfg_r, cfg_nxt;
   logic [15:0] maxfl_r, maxfl_nxt;
   logic wr_pend_r, wr_pend_nxt;
   logic [7:0] wr_addr_r, wr_addr_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic [31:0] status;
   logic busy;
   logic last_abort_r, last_abort_nxt;
   logic last_crcerr_r, last_crcerr_nxt;
   logic [15:0] last_cnt_r, last_cnt_nxt;

   // a frozen block stalls the bus rather than dropping a transfer
   assign hreadyout = ce;
   assign hresp = 1'b0;
   assign hrdata = rdata_r;

   always_comb begin
      status = 32'h00000000;
      status[ST_BUSY_BIT] = busy;
      status[ST_ABORT_BIT] = last_abort_r;
      status[ST_CRCERR_BIT] = last_crcerr_r;
      status[ST_CNT_LSB +: 16] = last_cnt_r;
   end

   always_comb begin
      cfg_nxt = cfg_r;
      maxfl_nxt = maxfl_r;
      wr_pend_nxt = 1'b0;
      wr_addr_nxt = wr_addr_r;
      rdata_nxt = rdata_r;
      if (wr_pend_r) begin
         case (wr_addr_r)
            REG_CTRL: cfg_nxt = hwdata[7:0] & CFG_MASK;
            REG_MAXFL: maxfl_nxt = hwdata[15:0];
            default: ;
         endcase
      end
      if (hsel && htrans[1] && hready) begin
         wr_pend_nxt = hwrite;
         wr_addr_nxt = haddr[ADDR_W-1:0];
         if (!hwrite) begin
            case (haddr[ADDR_W-1:0])
               REG_CTRL: rdata_nxt = {24'h000000, cfg_r};
               REG_MAXFL: rdata_nxt = {16'h0000, maxfl_r};
               REG_STATUS: rdata_nxt = status;
               default: rdata_nxt = 32'h00000000;
            endcase
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cfg_r <= CFG_RESET;
         maxfl_r <= MAXFL_RESET;
         wr_pend_r <= 1'b0;
         wr_addr_r <= 8'h00;
         rdata_r <= 32'h00000000;
      end else if (ce) begin
         cfg_r <= cfg_nxt;
         maxfl_r <= maxfl_nxt;
         wr_pend_r <= wr_pend_nxt;
         wr_addr_r <= wr_addr_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // frame engine
   mtfc_byte_if eng_s ();
   mtfc_byte_if tx_s ();

   mtfc_state_type st_r, st_nxt;
   logic [2:0] pre_r, pre_nxt;
   logic [1:0] fcs_r, fcs_nxt;
   logic [15:0] cnt_r, cnt_nxt, cnt_inc, pad_target;
   logic [31:0] crc_r, crc_nxt, crc_step;
   logic [7:0] crc_byte;
   logic crc_en_r, crc_en_nxt;
   logic pad_en_r, pad_en_nxt;
   logic pad64_r, pad64_nxt;
   logic vlan_det_r, vlan_det_nxt;
   logic huge_r, huge_nxt;
   logic type_hi_r, type_hi_nxt;
   logic is_vlan_r, is_vlan_nxt;
   logic abort_r, abort_nxt;
   logic giant, need_pad;
   logic [2:0] pad_code;

   assign busy = (st_r != ST_IDLE);
   assign cnt_inc = cnt_r + 16'h0001;
   assign pad_code = cfg_r[CFG_PAD_LSB +: 3];
   assign crc_byte = (st_r == ST_DATA) ? pkt_data : 8'h00;

   mtfc_crc_step u_crc (
      .crc_in (crc_r),
      .byte_in (crc_byte),
      .crc_out (crc_step)
   );

   always_comb begin
      if (pad64_r || (vlan_det_r && is_vlan_r)) begin
         pad_target = PAD_LONG;
      end else begin
         pad_target = PAD_SHORT;
      end
      need_pad = pad_en_r && (cnt_inc < pad_target);
      giant = !huge_r && !pkt_last && (cnt_inc >= maxfl_r);
   end

   always_comb begin
      st_nxt = st_r;
      pre_nxt = pre_r;
      fcs_nxt = fcs_r;
      cnt_nxt = cnt_r;
      crc_nxt = crc_r;
      crc_en_nxt = crc_en_r;
      pad_en_nxt = pad_en_r;
      pad64_nxt = pad64_r;
      vlan_det_nxt = vlan_det_r;
      huge_nxt = huge_r;
      type_hi_nxt = type_hi_r;
      is_vlan_nxt = is_vlan_r;
      abort_nxt = abort_r;
      last_abort_nxt = last_abort_r;
      last_crcerr_nxt = last_crcerr_r;
      last_cnt_nxt = last_cnt_r;
      pkt_ready = 1'b0;
      eng_s.valid = 1'b0;
      eng_s.data = 8'h00;
      eng_s.last = 1'b0;
      eng_s.err = 1'b0;
      case (st_r)
         ST_IDLE: begin
            // control byte is consumed here and never forwarded
            pkt_ready = 1'b1;
            if (pkt_valid) begin
               if (pkt_data[CB_OVERRIDE]) begin
                  crc_en_nxt = pkt_data[CB_CRC];
                  pad_en_nxt = pkt_data[CB_PAD];
                  pad64_nxt = 1'b0;
                  vlan_det_nxt = 1'b0;
                  huge_nxt = pkt_data[CB_HUGE];
               end else begin
                  // odd pad codes also imply a trailing
                  crc_en_nxt = cfg_r[CFG_CRC_BIT] | pad_code[0];
                  pad_en_nxt = pad_code[0];
                  pad64_nxt = pad_code[0] & pad_code[1];
                  vlan_det_nxt = (pad_code == PAD_VLAN);
                  huge_nxt = cfg_r[CFG_HUGE_BIT];
               end
               pre_nxt = 3'h0;
               fcs_nxt = 2'h0;
               cnt_nxt = 16'h0000;
               crc_nxt = CRC_INIT;
               type_hi_nxt = 1'b0;
               is_vlan_nxt = 1'b0;
               abort_nxt = 1'b0;
               st_nxt = ST_PRE;
            end
         end
         ST_PRE: begin
            eng_s.valid = 1'b1;
            eng_s.data = (pre_r == PRE_LAST) ? SFD_BYTE : PREAMBLE_BYTE;
            if (eng_s.ready) begin
               pre_nxt = pre_r + 3'h1;
               if (pre_r == PRE_LAST) begin
                  st_nxt = ST_DATA;
               end
            end
         end
         ST_DATA: begin
            eng_s.valid = pkt_valid;
            eng_s.data = pkt_data;
            eng_s.err = giant;
            eng_s.last = giant | (pkt_last & ~need_pad & ~crc_en_r);
            pkt_ready = eng_s.ready;
            if (pkt_valid && eng_s.ready) begin
               crc_nxt = crc_step;
               cnt_nxt = cnt_inc;
               if (cnt_r == TYPE_HI_IDX) begin
                  type_hi_nxt = (pkt_data == VLAN_HI);
               end
               if (cnt_r == TYPE_LO_IDX) begin
                  is_vlan_nxt = type_hi_r && (pkt_data == VLAN_LO);
               end
               if (giant) begin
                  abort_nxt = 1'b1;
                  st_nxt = ST_DRAIN;
               end else if (pkt_last) begin
                  if (need_pad) begin
                     st_nxt = ST_PAD;
                  end else if (crc_en_r) begin
                     st_nxt = ST_FCS;
                  end else begin
                     st_nxt = ST_DONE;
                  end
               end
            end
         end
         ST_PAD: begin
            eng_s.valid = 1'b1;
            eng_s.last = (cnt_inc == pad_target) && !crc_en_r;
            if (eng_s.ready) begin
               crc_nxt = crc_step;
               cnt_nxt = cnt_inc;
               if (cnt_inc == pad_target) begin
                  st_nxt = crc_en_r ? ST_FCS : ST_DONE;
               end
            end
         end
         ST_FCS: begin
            // check bytes go out low byte first, complemented
            eng_s.valid = 1'b1;
            eng_s.data = ~crc_r[7:0];
            eng_s.last = (fcs_r == FCS_LAST);
            if (eng_s.ready) begin
               crc_nxt = {8'h00, crc_r[31:8]};
               cnt_nxt = cnt_inc;
               fcs_nxt = fcs_r + 2'h1;
               if (fcs_r == FCS_LAST) begin
                  st_nxt = ST_DONE;
               end
            end
         end
         ST_DRAIN: begin
            // rest of a cut packet is read and thrown away
            pkt_ready = 1'b1;
            if (pkt_valid && pkt_last) begin
               st_nxt = ST_DONE;
            end
         end
         ST_DONE: begin
            last_abort_nxt = abort_r;
            // residue over data plus its own check bytes
            last_crcerr_nxt = !crc_en_r && !abort_r &&
                              (crc_r != CRC_RESIDUE);
            last_cnt_nxt = cnt_r;
            st_nxt = ST_IDLE;
         end
         default: st_nxt = ST_IDLE;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_r <= ST_IDLE;
         pre_r <= 3'h0;
         fcs_r <= 2'h0;
         cnt_r <= 16'h0000;
         crc_r <= CRC_INIT;
         crc_en_r <= 1'b0;
         pad_en_r <= 1'b0;
         pad64_r <= 1'b0;
         vlan_det_r <= 1'b0;
         huge_r <= 1'b0;
         type_hi_r <= 1'b0;
         is_vlan_r <= 1'b0;
         abort_r <= 1'b0;
         last_abort_r <= 1'b0;
         last_crcerr_r <= 1'b0;
         last_cnt_r <= 16'h0000;
      end else if (ce) begin
         st_r <= st_nxt;
         pre_r <= pre_nxt;
         fcs_r <= fcs_nxt;
         cnt_r <= cnt_nxt;
         crc_r <= crc_nxt;
         crc_en_r <= crc_en_nxt;
         pad_en_r <= pad_en_nxt;
         pad64_r <= pad64_nxt;
         vlan_det_r <= vlan_det_nxt;
         huge_r <= huge_nxt;
         type_hi_r <= type_hi_nxt;
         is_vlan_r <= is_vlan_nxt;
         abort_r <= abort_nxt;
         last_abort_r <= last_abort_nxt;
         last_crcerr_r <= last_crcerr_nxt;
         last_cnt_r <= last_cnt_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // output buffer toward the medium
   mtfc_skid_buf #(
      .DEPTH (2)
   ) u_buf (
      .hclk (hclk),
      .hresetn (hresetn),
      .ce (ce),
      .up (eng_s),
      .dn (tx_s)
   );

   // pkt_ready above is gated by the buffer's ready, so a stall reaches
   // the packet source; while ce is low nothing is popped
   assign tx_s.ready = tx_ready & ce;
   assign tx_data = tx_s.data;
   assign tx_valid = tx_s.valid;
   assign tx_last = tx_s.last;
   assign tx_abort = tx_s.err;

endmodule

// File: test/mtfc_checker.sv
// Purpose: port level checks of the transmit frame block
// Assumes: one clock, reset active low
// Notes: frame position is counted from bytes taken by the medium
`timescale 1ns/1ps
module mtfc_checker
   import mtfc_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic ce,
   input wire logic hsel,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic [31:0] hrdata,
   input wire logic pkt_valid,
   input wire logic pkt_last,
   input wire logic pkt_ready,
   input wire logic [7:0] tx_data,
   input wire logic tx_valid,
   input wire logic tx_last,
   input wire logic tx_abort,
   input wire logic tx_ready
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   logic [3:0] pos_r, pos_nxt;
   logic ctl_r, ctl_nxt;
   logic tx_take, pk_take, rd_take;
   assign tx_take = tx_valid && tx_ready && ce;
   assign pk_take = pkt_valid && pkt_ready && ce;
   assign rd_take = hsel && htrans[1] && !hwrite && hready && ce;
   // position saturates: only the first eight bytes matter here
   always_comb begin
      pos_nxt = pos_r;
      ctl_nxt = ctl_r;
      if (tx_take) begin
         pos_nxt = tx_last ? 4'h0 : pos_r + {3'h0, pos_r != 4'hF};
      end
      if (pk_take) begin
         ctl_nxt = !ctl_r && pkt_last;
      end
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pos_r <= 4'h0;
         ctl_r <= 1'b1;
      end else begin
         pos_r <= pos_nxt;
         ctl_r <= ctl_nxt;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   sequence s_ctrl_taken;
      pk_take && ctl_r;
   endsequence
   sequence s_tx_stalled;
      tx_valid && !(tx_ready && ce);
   endsequence
   a_preamble_bytes: assert property (
      tx_take && pos_r < 4'h7 |-> tx_data == PREAMBLE_BYTE && !tx_last)
      else $error("bad preamble byte");
   a_sfd_byte: assert property (
      tx_take && pos_r == 4'h7 |-> tx_data == SFD_BYTE && !tx_last)
      else $error("bad start delimiter");
   a_last_after_sfd: assert property (
      tx_take && tx_last |-> pos_r > 4'h7)
      else $error("frame ended inside preamble");
   a_abort_with_last: assert property (
      tx_valid && tx_abort |-> tx_last) else $error("abort without last");
   a_ctrl_pauses: assert property (
      s_ctrl_taken |=> !pkt_ready [*8]) else $error("byte taken in preamble");
   a_tx_held: assert property (
      s_tx_stalled |=> tx_valid && $stable({tx_data, tx_last, tx_abort}))
      else $error("medium byte changed while stalled");
   a_ce_freeze: assert property (
      !ce |=> $stable({tx_valid, tx_data, tx_last, tx_abort}))
      else $error("state moved with clock enable low");
   a_bus_zero_wait: assert property (hreadyout == ce)
      else $error("wait state inserted");
   a_resp_okay: assert property (hresp == 1'b0) else $error("error response");
   a_read_stands: assert property (!$past(rd_take) |-> $stable(hrdata))
      else $error("read data changed without a read");
endmodule
bind mtfc_top mtfc_checker u_chk (.hclk, .hresetn, .ce, .hsel, .htrans,
   .hwrite, .hready, .hreadyout, .hresp, .hrdata, .pkt_valid, .pkt_last,
   .pkt_ready, .tx_data, .tx_valid, .tx_last, .tx_abort, .tx_ready);

// File: test/mtfc_host_model.sv
// Purpose: host side handing packets out of buffer memory
// Assumes: same clock as the block
// Notes: idle data shows the inverse of the last byte, never a held value
`timescale 1ns/1ps
module mtfc_host_model
   import mtfc_pkg::*;
(
   input wire logic hclk,
   input wire logic ce,
   input wire logic pkt_ready,
   output logic [7:0] pkt_data,
   output logic pkt_valid,
   output logic pkt_last
);
   initial begin
      pkt_data = 8'h00;
      pkt_valid = 1'b0;
      pkt_last = 1'b0;
   end
   // control byte first, then every frame field the block does not add
   task automatic send_pkt(input logic [7:0] q[$], input bit slow);
      logic ok;
      foreach (q[i]) begin
         pkt_data <= q[i];
         pkt_valid <= 1'b1;
         pkt_last <= (i == q.size() - 1);
         // ready is combinational, so look at it away from the edge
         do begin
            @(negedge hclk);
            ok = pkt_ready && ce;
            @(posedge hclk);
         end while (ok !== 1'b1);
         if (slow || i == q.size() - 1) begin
            pkt_valid <= 1'b0;
            pkt_last <= 1'b0;
            pkt_data <= ~q[i];
            @(posedge hclk);
         end
      end
   endtask
endmodule

// File: test/mac_tx_frame_control_test.sv
// Purpose: frame assembly tests through registers and packet stream
// Assumes: max frame length set to 24 data bytes
// Notes: medium side stalls and clock enable drops in some frames
`timescale 1ns/1ps
module mac_tx_frame_control_test
   import mtfc_pkg::*;
   ;
   localparam int MAXFL_SET = 24;
   logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, dummy;
   logic [1:0] htrans;
   logic [2:0] hsize = 3'h2;
   logic [7:0] pkt_data, tx_data;
   logic pkt_valid, pkt_last, pkt_ready, tx_valid, tx_last, tx_abort;
   logic ce = 1'b1;
   logic tx_ready = 1'b1;
   logic stall = 1'b0;
   // marks bytes 12..13 of the next frame as a vlan type field
   logic vtag = 1'b0;
   int err_count = 0;
   int checks_done = 0;
   int cyc = 0;
   logic [9:0] exp_q[$];
   assign hready = hreadyout;
   mtfc_top u_dut (.hclk, .hresetn, .ce, .hsel, .haddr, .htrans, .hwrite,
      .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata, .pkt_data,
      .pkt_valid, .pkt_last, .pkt_ready, .tx_data, .tx_valid, .tx_last,
      .tx_abort, .tx_ready);
   mtfc_host_model u_host (.hclk, .ce, .pkt_ready, .pkt_data, .pkt_valid,
      .pkt_last);
   initial begin
      hclk = 1'b0;
      forever #10 hclk = ~hclk;
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      checks_done++;
      if (seen !== want) begin
         err_count++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, want);
      end
   endtask
   task automatic tally_and_finish();
      $display("mismatches %0d of %0d checks", err_count, checks_done);
      if (err_count == 0 && checks_done > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic bus_step();
      logic k;
      do begin
         @(negedge hclk);
         k = hreadyout;
         @(posedge hclk);
      end while (k !== 1'b1);
   endtask
   task automatic ahb(input logic w, input logic [7:0] a,
         input logic [31:0] wd, output logic [31:0] rd);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h000000, a};
      hwrite <= w;
      bus_step();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      bus_step();
      rd = hrdata;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] want);
      logic [31:0] v;
      ahb(1'b0, a, 32'h00000000, v);
      check(v, want);
   endtask
   function automatic logic [31:0] crc_add(logic [31:0] c, logic [7:0] b);
      c = c ^ {24'h000000, b};
      for (int i = 0; i < 8; i++) c = c[0] ? (c >> 1) ^ CRC_POLY : c >> 1;
      return c;
   endfunction
   // medium side: stalls three cycles in four while stall is set
   always @(posedge hclk) begin
      cyc <= cyc + 1;
      tx_ready <= !stall || cyc[1:0] == 2'h0;
      ce <= !(stall && cyc[3:0] == 4'h5);
   end
   always @(negedge hclk) begin
      logic [9:0] want;
      if (tx_valid === 1'b1 && tx_ready && ce) begin
         want = exp_q.size() > 0 ? exp_q.pop_front() : 10'h3FF;
         check(32'({tx_abort, tx_last, tx_data}), 32'(want));
      end
   end
   // one packet: expected frame built from the host bytes
   task automatic run(input logic [7:0] cfg, input logic [7:0] cb,
         input int n, input int pad, input bit crc, input bit cut,
         input bit good, input bit err, input bit slow);
      logic [7:0] q[$];
      logic [7:0] f[$];
      logic [31:0] c, v;
      int k;
      ahb(1'b1, REG_CTRL, {24'h000000, cfg}, v);
      for (int i = 0; i < n; i++) f.push_back(8'(i * 37 + 5));
      if (vtag) begin
         f[12] = VLAN_HI;
         f[13] = VLAN_LO;
      end
      c = CRC_INIT;
      foreach (f[i]) c = crc_add(c, f[i]);
      if (good) for (int i = 0; i < 4; i++) f.push_back(8'(~c >> (8 * i)));
      q = {cb, f};
      if (cut) f = f[0:MAXFL_SET - 1];
      while (f.size() < pad) f.push_back(8'h00);
      c = CRC_INIT;
      foreach (f[i]) c = crc_add(c, f[i]);
      // a cut frame ends on its aborted byte, no check follows it
      if (crc && !cut) begin
         for (int i = 0; i < 4; i++) f.push_back(8'(~c >> (8 * i)));
      end
      for (int i = 0; i < 8; i++) begin
         exp_q.push_back({2'b00, i < 7 ? PREAMBLE_BYTE : SFD_BYTE});
      end
      foreach (f[i]) begin
         exp_q.push_back({cut && i == f.size() - 1, i == f.size() - 1, f[i]});
      end
      stall <= slow;
      u_host.send_pkt(q, slow);
      k = 0;
      do begin
         ahb(1'b0, REG_STATUS, 32'h00000000, v);
         k++;
      end while ((v[ST_BUSY_BIT] !== 1'b0 || exp_q.size() > 0) && k < 400);
      check(v, {16'(f.size()), 13'h0000, err, cut, 1'b0});
      stall <= 1'b0;
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h00000000;
      htrans = 2'h0;
      hwrite = 1'b0;
      hwdata = 32'h00000000;
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      rd_chk(REG_CTRL, 32'h00000000);
      rd_chk(REG_MAXFL, 32'h000005EE);
      rd_chk(REG_STATUS, 32'h00000000);
      ahb(1'b1, 8'h0C, 32'hFFFFFFFF, dummy);
      rd_chk(8'h0C, 32'h00000000);
      ahb(1'b1, REG_CTRL, 32'hFFFFFFFF, dummy);
      rd_chk(REG_CTRL, 32'h000000F4);
      ahb(1'b1, REG_MAXFL, 32'(MAXFL_SET), dummy);
      rd_chk(REG_MAXFL, 32'(MAXFL_SET));
      run(8'h00, 8'hF7, 20, 60, 1, 0, 0, 0, 0);
      run(8'h30, 8'h01, 20, 0, 0, 0, 0, 1, 0);
      run(8'h00, 8'h01, 20, 0, 0, 0, 1, 0, 0);
      run(8'h00, 8'h03, 30, 0, 1, 1, 0, 0, 0);
      run(8'h00, 8'h0B, 30, 0, 1, 0, 0, 0, 0);
      run(8'h30, 8'h0E, 20, 60, 1, 0, 0, 0, 0);
      run(8'h70, 8'h00, 20, 64, 1, 0, 0, 0, 0);
      run(8'hF0, 8'h00, 20, 64, 1, 0, 0, 0, 0);
      run(8'h50, 8'h00, 20, 0, 1, 0, 0, 0, 0);
      run(8'h00, 8'h00, 20, 0, 0, 0, 0, 1, 0);
      run(8'h10, 8'h00, 30, 0, 1, 1, 0, 0, 1);
      run(8'h14, 8'h00, 30, 0, 1, 0, 0, 0, 1);
      vtag = 1'b1;
      run(8'hB0, 8'h00, 20, 64, 1, 0, 0, 0, 0);
      vtag = 1'b0;
      run(8'hA0, 8'h00, 20, 60, 1, 0, 0, 0, 0);
      tally_and_finish();
   end
   // fourteen frames take well under two thousand cycles; this allows far more
   initial begin
      #1000000;
      err_count++;
      tally_and_finish();
   end
endmodule
